//--- bbc_params.svh
// constants for the blanking and burst control block
`ifndef BBC_PARAMS_SVH
`define BBC_PARAMS_SVH
// time base
`define BBC_CLK_PERIOD_NS 25
`define BBC_TICK_NS 1000
`define BBC_TICK_CYC (`BBC_TICK_NS / `BBC_CLK_PERIOD_NS)
// intervals in their own units and as tick counts
`define BBC_BLANK_TIME_MS 20
`define BBC_BLANK_TICKS (`BBC_BLANK_TIME_MS * 1000000 / `BBC_TICK_NS)
`define BBC_DETECT_TIME_MS 1
`define BBC_DETECT_TICKS (`BBC_DETECT_TIME_MS * 1000000 / `BBC_TICK_NS)
`define BBC_SPIKE_TIME_US 30
`define BBC_SPIKE_TICKS ((`BBC_SPIKE_TIME_US * 1000 + `BBC_TICK_NS - 1) / `BBC_TICK_NS)
`define BBC_BURST_TIME_MS 20
`define BBC_BURST_TICKS (`BBC_BURST_TIME_MS * 1000000 / `BBC_TICK_NS)
// extension cycle count
`define BBC_EXT_COUNT_MAX 256
// detection count thresholds (more cycles means smaller capacitor)
`define BBC_DET_TH_142 16
`define BBC_DET_TH_127 64
`define BBC_DET_TH_NEVER 512
// level select codes
`define BBC_LVL_160 2'h0
`define BBC_LVL_142 2'h1
`define BBC_LVL_127 2'h2
`define BBC_LVL_NEVER 2'h3
// register byte offsets
`define BBC_REG_CTRL 8'h00
`define BBC_REG_STATUS 8'h04
`define BBC_REG_EXTCNT 8'h08
`define BBC_REG_DETCNT 8'h0C
// control field position and reset value
`define BBC_CTRL_EXTEND 0
`define BBC_CTRL_RESET 1'h0
// bus responses
`define BBC_RESP_OKAY 2'h0
`define BBC_RESP_SLVERR 2'h2
`endif

//--- bbc_pkg.sv
// types shared by the blanking and burst control block
package bbc_pkg;
    // synchronised comparator inputs
    typedef struct packed {
        logic ext_upper;
        logic ext_lower;
        logic overload;
        logic det_upper;
        logic det_lower;
        logic entry_below;
        logic wake;
        logic sleep;
        logic exit_above;
    } bbc_cmp_t;
    typedef enum logic [1:0] {EXT_IDLE, EXT_CHARGE, EXT_DISCH, EXT_DONE} bbc_ext_state_t;
    typedef enum logic [1:0] {DET_WAIT, DET_RUN, DET_DONE} bbc_det_state_t;
    typedef enum logic [1:0] {BU_NORMAL, BU_SLEEP, BU_ACTIVE} bbc_burst_state_t;
endpackage

//--- bbc_timer.sv
// tick-counting interval timer, cleared while not running
`timescale 1ns/1ps
module bbc_timer #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic run,
    input wire logic tick,
    input wire logic [W-1:0] limit,
    // status
    output logic done
);
    logic [W-1:0] cnt_r;

    // count ticks while running, hold at limit
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !run)
            cnt_r <= '0;
        else if (tick && cnt_r != limit)
            cnt_r <= cnt_r + 1'b1;
    end

    assign done = run && (cnt_r == limit);
endmodule // bbc_timer

//--- bbc_blank_burst.sv
// blanking, extension, burst level detection and burst mode control
`timescale 1ns/1ps
`include "bbc_params.svh"
module bbc_blank_burst
    import bbc_pkg::*;
#(
    parameter int TW = 16,
    parameter int CW = 10,
    parameter logic [TW-1:0] BLANK_TICKS = TW'(`BBC_BLANK_TICKS),
    parameter logic [TW-1:0] DETECT_TICKS = TW'(`BBC_DETECT_TICKS),
    parameter logic [TW-1:0] SPIKE_TICKS = TW'(`BBC_SPIKE_TICKS),
    parameter logic [TW-1:0] BURST_TICKS = TW'(`BBC_BURST_TICKS),
    parameter logic [8:0] EXT_COUNT_MAX = 9'(`BBC_EXT_COUNT_MAX)
) (
    // clock and reset (reset at undervoltage lockout)
    input wire logic aclk,
    input wire logic aresetn,
    // start-up context
    input wire logic restart_cycle,
    input wire logic protection_hold,
    // analog comparators
    input wire bbc_cmp_t cmp_in,
    // analog switches and controls
    output logic extend_charge_switch,
    output logic extend_discharge_switch,
    output logic detect_discharge_switch,
    output logic autorestart_trigger,
    output logic bias_enable,
    output logic burst_flag,
    output logic burst_limit_gate,
    output logic [1:0] burst_level_sel,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam logic [5:0] TICK_LAST = 6'(`BBC_TICK_CYC - 1);

    bbc_cmp_t sync1_r;
    bbc_cmp_t cmp_r;
    logic [5:0] div_r;
    logic tick_r;
    bbc_ext_state_t ext_state_r;
    bbc_det_state_t det_state_r;
    bbc_burst_state_t burst_state_r;
    logic [8:0] ext_count_r;
    logic [CW-1:0] det_count_r;
    logic detect_flipflop_r;
    logic extend_en_r;
    logic blank_done;
    logic detect_done;
    logic spike_done;
    logic entry_done;
    logic ext_out;
    logic restart_and_gate;
    logic entry_run;
    logic aw_got_r;
    logic w_got_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic aw_hs;
    logic w_hs;
    logic do_write;
    logic ar_hs;
    logic [31:0] rd_data;
    logic rd_ok;

    // two-stage comparator synchroniser
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_r <= '0;
            cmp_r <= '0;
        end
        else
        begin
            sync1_r <= cmp_in;
            cmp_r <= sync1_r;
        end
    end

    // 1 us time-base enable
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_r <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            tick_r <= (div_r == TICK_LAST);
            div_r <= (div_r == TICK_LAST) ? '0 : div_r + 1'b1;
        end
    end

    // built-in blanking runs while overload persists
    bbc_timer #(.W(TW)) u_blank (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(cmp_r.overload),
        .tick(tick_r),
        .limit(BLANK_TICKS),
        .done(blank_done)
    );

    // extension output and restart gate
    assign ext_out = (ext_state_r == EXT_DONE);
    assign restart_and_gate = blank_done && (extend_en_r ? ext_out : 1'b1);

    // spike blanking after the restart gate opens
    bbc_timer #(.W(TW)) u_spike (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(restart_and_gate),
        .tick(tick_r),
        .limit(SPIKE_TICKS),
        .done(spike_done)
    );

    // extension charge/discharge cycling
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !cmp_r.overload || !extend_en_r)
        begin
            ext_state_r <= EXT_IDLE;
            ext_count_r <= '0;
        end
        else
        begin
            unique case (ext_state_r)
                EXT_IDLE:
                    if (blank_done)
                        ext_state_r <= EXT_CHARGE;
                EXT_CHARGE:
                    if (cmp_r.ext_upper)
                    begin
                        ext_count_r <= ext_count_r + 1'b1;
                        ext_state_r <= (ext_count_r + 1'b1 == EXT_COUNT_MAX) ?
                            EXT_DONE : EXT_DISCH;
                    end
                EXT_DISCH:
                    if (cmp_r.ext_lower)
                        ext_state_r <= EXT_CHARGE;
                EXT_DONE:
                    ext_state_r <= EXT_DONE;
            endcase
        end
    end

    // extension switch drive and restart trigger
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            extend_charge_switch <= 1'b0;
            extend_discharge_switch <= 1'b0;
            autorestart_trigger <= 1'b0;
        end
        else
        begin
            extend_charge_switch <= (ext_state_r == EXT_CHARGE);
            extend_discharge_switch <= (ext_state_r == EXT_DISCH);
            autorestart_trigger <= spike_done;
        end
    end

    // 1 ms detection window
    bbc_timer #(.W(TW)) u_detect (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(det_state_r == DET_RUN),
        .tick(tick_r),
        .limit(DETECT_TICKS),
        .done(detect_done)
    );

    // burst level detection sequence
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            det_state_r <= DET_WAIT;
            detect_flipflop_r <= 1'b0;
            det_count_r <= '0;
            burst_level_sel <= `BBC_LVL_160;
        end
        else
        begin
            unique case (det_state_r)
                DET_WAIT:
                    if (restart_cycle)
                        det_state_r <= DET_DONE;
                    else if (!protection_hold)
                        det_state_r <= DET_RUN;
                DET_RUN:
                begin
                    if (detect_done)
                    begin
                        det_state_r <= DET_DONE;
                        detect_flipflop_r <= 1'b0;
                        if (det_count_r >= CW'(`BBC_DET_TH_NEVER))
                            burst_level_sel <= `BBC_LVL_NEVER;
                        else if (det_count_r >= CW'(`BBC_DET_TH_127))
                            burst_level_sel <= `BBC_LVL_127;
                        else if (det_count_r >= CW'(`BBC_DET_TH_142))
                            burst_level_sel <= `BBC_LVL_142;
                        else
                            burst_level_sel <= `BBC_LVL_160;
                    end
                    else if (!detect_flipflop_r && cmp_r.det_upper)
                    begin
                        detect_flipflop_r <= 1'b1;
                        if (det_count_r != '1)
                            det_count_r <= det_count_r + 1'b1;
                    end
                    else if (detect_flipflop_r && cmp_r.det_lower)
                        detect_flipflop_r <= 1'b0;
                end
                DET_DONE:
                    det_state_r <= DET_DONE;
                default:
                    det_state_r <= DET_WAIT;
            endcase
        end
    end

    // discharge switch follows the detect flop
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            detect_discharge_switch <= 1'b0;
        else
            detect_discharge_switch <= detect_flipflop_r;
    end

    // burst entry blanking
    assign entry_run = (burst_state_r == BU_NORMAL) && (det_state_r == DET_DONE) &&
        (burst_level_sel != `BBC_LVL_NEVER) && cmp_r.entry_below;
    bbc_timer #(.W(TW)) u_entry (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(entry_run),
        .tick(tick_r),
        .limit(BURST_TICKS),
        .done(entry_done)
    );

    // burst mode state machine
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            burst_state_r <= BU_NORMAL;
        else
        begin
            unique case (burst_state_r)
                BU_NORMAL:
                    if (entry_done)
                        burst_state_r <= BU_SLEEP;
                BU_SLEEP:
                    if (cmp_r.exit_above)
                        burst_state_r <= BU_NORMAL;
                    else if (cmp_r.wake)
                        burst_state_r <= BU_ACTIVE;
                BU_ACTIVE:
                    if (cmp_r.exit_above)
                        burst_state_r <= BU_NORMAL;
                    else if (cmp_r.sleep)
                        burst_state_r <= BU_SLEEP;
                default:
                    burst_state_r <= BU_NORMAL;
            endcase
        end
    end

    // burst outputs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bias_enable <= 1'b1;
            burst_flag <= 1'b0;
            burst_limit_gate <= 1'b0;
        end
        else
        begin
            bias_enable <= (burst_state_r != BU_SLEEP);
            burst_flag <= (burst_state_r != BU_NORMAL);
            burst_limit_gate <= (burst_state_r != BU_NORMAL);
        end
    end

    // axi4-lite write channel
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign do_write = aw_got_r && w_got_r && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `BBC_RESP_OKAY;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            else if (do_write)
                aw_got_r <= 1'b0;
            if (w_hs)
            begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            else if (do_write)
                w_got_r <= 1'b0;
            s_axi_awready <= !aw_got_r && !aw_hs && !s_axi_bvalid;
            s_axi_wready <= !w_got_r && !w_hs && !s_axi_bvalid;
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_r[7:2] <= `BBC_REG_DETCNT >> 2) ?
                    `BBC_RESP_OKAY : `BBC_RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // control register steers the blanking mode
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            extend_en_r <= `BBC_CTRL_RESET;
        else if (do_write && awaddr_r[7:2] == `BBC_REG_CTRL >> 2 && wstrb_r[0])
            extend_en_r <= wdata_r[`BBC_CTRL_EXTEND];
    end

    // read decode
    always_comb
    begin
        rd_data = '0;
        rd_ok = 1'b1;
        unique case (s_axi_araddr[7:2])
            `BBC_REG_CTRL >> 2: rd_data[`BBC_CTRL_EXTEND] = extend_en_r;
            `BBC_REG_STATUS >> 2: rd_data[9:0] = {ext_out, autorestart_trigger,
                det_state_r == DET_DONE, burst_level_sel, burst_limit_gate,
                burst_flag, bias_enable, burst_state_r};
            `BBC_REG_EXTCNT >> 2: rd_data[8:0] = ext_count_r;
            `BBC_REG_DETCNT >> 2: rd_data[CW-1:0] = det_count_r;
            default: rd_ok = 1'b0;
        endcase
    end

    // axi4-lite read channel
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `BBC_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !ar_hs && !s_axi_rvalid;
            if (ar_hs)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_ok ? `BBC_RESP_OKAY : `BBC_RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule // bbc_blank_burst

//--- bbc_analog_model.sv
// behavioural model of the extension and feedback capacitors with their comparators
`timescale 1ns/1ps
module bbc_analog_model #(
    parameter int EXT_STEPS = 20,
    parameter int FB_STEPS = 4
) (
    // clock
    input wire logic aclk,
    // switches from the block
    input wire logic extend_charge_switch,
    input wire logic extend_discharge_switch,
    input wire logic detect_discharge_switch,
    // comparator outputs
    output logic ext_upper,
    output logic ext_lower,
    output logic det_upper,
    output logic det_lower
);
    int ext_v = 0;
    int fb_v = 0;
    // extension pin: charged by the source, drained through the resistor, else held
    always_ff @(posedge aclk)
    begin
        if (extend_discharge_switch && ext_v > 0)
            ext_v <= ext_v - 1;
        else if (extend_charge_switch && !extend_discharge_switch && ext_v < EXT_STEPS)
            ext_v <= ext_v + 1;
    end
    // feedback pin: always charged unless the discharge switch is closed
    always_ff @(posedge aclk)
    begin
        if (detect_discharge_switch && fb_v > 0)
            fb_v <= fb_v - 1;
        else if (!detect_discharge_switch && fb_v < FB_STEPS)
            fb_v <= fb_v + 1;
    end
    // threshold comparators
    assign ext_upper = ext_v >= EXT_STEPS;
    assign ext_lower = ext_v == 0;
    assign det_upper = fb_v >= FB_STEPS;
    assign det_lower = fb_v == 0;
endmodule // bbc_analog_model

//--- bbc_blank_burst_assertions.sv
// concurrent checks on the ports of the blanking and burst control block
`timescale 1ns/1ps
module bbc_blank_burst_assertions
    import bbc_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // start-up context
    input wire logic restart_cycle,
    input wire logic protection_hold,
    // comparators
    input wire bbc_cmp_t cmp_in,
    // switches and controls
    input wire logic extend_charge_switch,
    input wire logic extend_discharge_switch,
    input wire logic detect_discharge_switch,
    input wire logic autorestart_trigger,
    input wire logic bias_enable,
    input wire logic burst_flag,
    input wire logic burst_limit_gate,
    input wire logic [1:0] burst_level_sel
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // outputs as reset leaves them
    a_reset_outputs: assert property ($rose(aresetn) |-> bias_enable && !burst_flag)
        else $error("outputs not at reset values");
    a_switch_exclusive: assert property (!(extend_charge_switch
        && extend_discharge_switch))
        else $error("both extension switches closed");
    a_discharge_cause: assert property ($rose(extend_discharge_switch)
        |-> $past(cmp_in.ext_upper))
        else $error("discharge without upper trip");
    a_recharge_cause: assert property ($fell(extend_discharge_switch)
        && extend_charge_switch |-> $past(cmp_in.ext_lower))
        else $error("recharge without lower trip");
    a_detect_cause: assert property ($rose(detect_discharge_switch)
        |-> $past(cmp_in.det_upper))
        else $error("detect discharge without upper trip");
    a_detect_held: assert property (protection_hold || restart_cycle
        |-> !detect_discharge_switch)
        else $error("detection while held or on restart");
    a_restart_done: assert property ($rose(autorestart_trigger)
        |-> !extend_charge_switch && !extend_discharge_switch)
        else $error("restart while extension runs");
    a_restart_load: assert property ($rose(autorestart_trigger)
        |-> $past(cmp_in.overload, 3))
        else $error("restart without overload");
    a_flag_gate: assert property (burst_flag == burst_limit_gate)
        else $error("limit gate differs from burst flag");
    a_bias_outside: assert property (!burst_flag |-> bias_enable)
        else $error("bias off outside burst");
    a_entry_bias: assert property ($rose(burst_flag) |-> !bias_enable)
        else $error("bias on at burst entry");
    a_never_burst: assert property (burst_level_sel == 2'h3 |-> !burst_flag)
        else $error("burst with never level");
    a_wake_bias: assert property (burst_flag && cmp_in.wake && !cmp_in.sleep
        |-> ##[1:4] bias_enable)
        else $error("bias not woken");
    a_sleep_bias: assert property (burst_flag && cmp_in.sleep && !cmp_in.wake
        && !cmp_in.exit_above |-> ##[1:4] !bias_enable)
        else $error("bias not put to sleep");
    a_exit_burst: assert property (cmp_in.exit_above [*3] |-> ##[0:2] !burst_flag)
        else $error("burst not left");
    // main scenarios
    c_burst: cover property ($rose(burst_flag));
    c_restart: cover property ($rose(autorestart_trigger));
    c_detect: cover property ($rose(detect_discharge_switch));
endmodule // bbc_blank_burst_assertions
bind bbc_blank_burst bbc_blank_burst_assertions i_chk (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart_cycle(restart_cycle),
    .protection_hold(protection_hold),
    .cmp_in(cmp_in),
    .extend_charge_switch(extend_charge_switch),
    .extend_discharge_switch(extend_discharge_switch),
    .detect_discharge_switch(detect_discharge_switch),
    .autorestart_trigger(autorestart_trigger),
    .bias_enable(bias_enable),
    .burst_flag(burst_flag),
    .burst_limit_gate(burst_limit_gate),
    .burst_level_sel(burst_level_sel)
);

//--- testbench.sv
// self-checking bench for the blanking and burst control block
`timescale 1ns/1ps
module testbench;
    import bbc_pkg::*;
    logic aclk, aresetn, restart_cycle, protection_hold;
    bbc_cmp_t cmp_tb, cmp_in;
    logic ext_upper, ext_lower, det_upper, det_lower;
    logic charge_sw, disch_sw, det_sw, restart_trig, bias_en, flag, gate;
    logic [1:0] lvl, bresp, rresp;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    int num_errors, tests_run;
    // block with shortened intervals
    bbc_blank_burst #(.BLANK_TICKS(16'h14), .DETECT_TICKS(16'hA), .SPIKE_TICKS(16'h3),
        .BURST_TICKS(16'h14), .EXT_COUNT_MAX(9'h4)) i_dut (.aclk(aclk), .aresetn(aresetn),
        .restart_cycle(restart_cycle), .protection_hold(protection_hold), .cmp_in(cmp_in),
        .extend_charge_switch(charge_sw), .extend_discharge_switch(disch_sw),
        .detect_discharge_switch(det_sw), .autorestart_trigger(restart_trig),
        .bias_enable(bias_en), .burst_flag(flag), .burst_limit_gate(gate),
        .burst_level_sel(lvl), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    bbc_analog_model i_ana (.aclk(aclk), .extend_charge_switch(charge_sw),
        .extend_discharge_switch(disch_sw), .detect_discharge_switch(det_sw),
        .ext_upper(ext_upper), .ext_lower(ext_lower), .det_upper(det_upper),
        .det_lower(det_lower));
    // comparators: capacitor pins from the model, the rest from the bench
    always_comb
    begin
        cmp_in = cmp_tb;
        cmp_in.ext_upper = ext_upper;
        cmp_in.ext_lower = ext_lower;
        cmp_in.det_upper = det_upper;
        cmp_in.det_lower = det_lower;
    end
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    task tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1)
        begin
            $display("BAD %0t %s", $time, msg);
            num_errors++;
        end
    endtask
    task tally_and_finish();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (awready !== 1'b1);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (wready !== 1'b1);
                wvalid <= 1'b0;
            end
        join
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // watch the detect switch for n cycles
    task watch_det(input int n, output logic seen);
        seen = 1'b0;
        repeat (n)
        begin
            @(posedge aclk);
            seen = seen | det_sw;
        end
    endtask
    task pulse(input int b);
        cmp_tb[b] <= 1'b1;
        tick(5);
        cmp_tb[b] <= 1'b0;
        tick(5);
    endtask
    task t_detect();
        logic seen;
        logic [31:0] d;
        logic [1:0] r;
        watch_det(300, seen);
        check(!seen, "detection while held");
        protection_hold <= 1'b0;
        repeat (100) if (det_sw !== 1'b1) @(posedge aclk);
        check(det_sw === 1'b1, "no detect discharge");
        repeat (60) if (det_sw !== 1'b0) @(posedge aclk);
        check(det_sw === 1'b0, "detect switch stuck");
        tick(600);
        check(lvl === 2'h1, "wrong burst level");
        axi_read(8'h0C, d, r);
        check(d >= 32'h10 && d < 32'h40, "detect count");
        axi_read(8'h04, d, r);
        check(d[7] === 1'b1, "detection not done");
        watch_det(200, seen);
        check(!seen, "detection after window");
    endtask
    task t_bus();
        logic [31:0] d;
        logic [1:0] r;
        axi_read(8'h10, d, r);
        check(r === 2'h2, "unmapped read accepted");
        axi_write(8'h20, 32'h1, r);
        check(r === 2'h2, "unmapped write accepted");
    endtask
    task t_basic();
        cmp_tb.overload <= 1'b1;
        tick(850);
        check(restart_trig === 1'b0 && charge_sw === 1'b0, "restart early");
        repeat (150) if (restart_trig !== 1'b1) @(posedge aclk);
        check(restart_trig === 1'b1, "no restart");
        cmp_tb.overload <= 1'b0;
        tick(5);
        check(!restart_trig, "restart not cleared");
    endtask
    task t_extend();
        logic [31:0] d;
        logic [1:0] r;
        axi_write(8'h00, 32'h1, r);
        axi_read(8'h00, d, r);
        check(d === 32'h1, "control readback");
        cmp_tb.overload <= 1'b1;
        tick(760);
        check(charge_sw === 1'b0 && disch_sw === 1'b0, "extension early");
        repeat (200) if (charge_sw !== 1'b1 && disch_sw !== 1'b1) @(posedge aclk);
        check(charge_sw === 1'b1 && disch_sw === 1'b0, "no charge start");
        check(restart_trig === 1'b0, "gate open in extension");
        repeat (600) if (restart_trig !== 1'b1) @(posedge aclk);
        check(restart_trig === 1'b1 && charge_sw === 1'b0, "extension not done");
        axi_read(8'h08, d, r);
        check(d === 32'h4, "extension count");
        cmp_tb.overload <= 1'b0;
    endtask
    task t_burst();
        cmp_tb.entry_below <= 1'b1;
        tick(400);
        cmp_tb.entry_below <= 1'b0;
        tick(10);
        cmp_tb.entry_below <= 1'b1;
        tick(760);
        check(!flag, "burst early");
        repeat (200) if (flag !== 1'b1) @(posedge aclk);
        check(flag === 1'b1 && bias_en === 1'b0, "no burst sleep");
        check(gate === 1'b1, "limit gate blocked");
        cmp_tb.entry_below <= 1'b0;
        pulse(2);
        check(bias_en === 1'b1 && flag === 1'b1, "bias not woken");
        pulse(1);
        check(bias_en === 1'b0 && gate === 1'b1, "bias not asleep");
        pulse(0);
        check(flag === 1'b0 && gate === 1'b0 && bias_en === 1'b1, "burst kept");
    endtask
    task t_restart();
        logic seen;
        aresetn <= 1'b0;
        restart_cycle <= 1'b1;
        tick(10);
        aresetn <= 1'b1;
        tick(2);
        check(bias_en === 1'b1 && flag === 1'b0 && lvl === 2'h0, "reset values");
        watch_det(600, seen);
        check(!seen && lvl === 2'h0, "detection on restart");
    endtask
    initial
    begin
        aresetn = 1'b0;
        restart_cycle = 1'b0;
        protection_hold = 1'b1;
        cmp_tb = '0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        num_errors = 0;
        tests_run = 0;
        tick(10);
        aresetn <= 1'b1;
        tick(2);
        check(bias_en === 1'b1 && flag === 1'b0 && restart_trig === 1'b0, "reset values");
        t_detect();
        t_bus();
        t_basic();
        t_extend();
        t_burst();
        t_restart();
        tally_and_finish();
    end
    // hang guard
    initial
    begin
        tick(20000);
        num_errors++;
        tally_and_finish();
    end
endmodule // testbench
